/* include/rtcc_pkg.sv */
// package: offsets, field positions, reset values and carrier types of the retry/card control block
package rtcc_pkg;

    // configuration offsets of the two registers
    localparam logic [7:0] RTCC_OFS_RETRY    = 8'h90;
    localparam logic [7:0] RTCC_OFS_CARD     = 8'h91;

    // function numbers; function 0 owns the global bits
    localparam logic       RTCC_FUNC_GLOBAL  = 1'h0;

    // retry_timeout_status field positions
    localparam int         RTCC_RS_HOST_EN   = 7;
    localparam int         RTCC_RS_CARD_EN   = 6;
    localparam int         RTCC_RS_EXP_B     = 5;
    localparam int         RTCC_RS_EXP_A     = 3;
    localparam int         RTCC_RS_EXP_HOST  = 1;

    // socket_card_control field positions
    localparam int         RTCC_CC_RING_EN   = 7;
    localparam int         RTCC_CC_ZV_EN     = 6;
    localparam int         RTCC_CC_PORT_SEL  = 5;
    localparam int         RTCC_CC_AUD_EN    = 2;
    localparam int         RTCC_CC_SPK_EN    = 1;
    localparam int         RTCC_CC_IRQ_FLAG  = 0;

    // reset values
    localparam logic       RTCC_RST_TIMER_EN = 1'h1;
    localparam logic       RTCC_RST_FLAG     = 1'h0;
    localparam logic [7:0] RTCC_RST_RDATA    = 8'h00;

    // retry timeout length in pci clock cycles (2^15)
    localparam int         RTCC_RETRY_CYCLES = 32768;

    // configuration request carried from the config decoder
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       func;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rtcc_cfg_req_t;

    // per-socket control bits of socket_card_control
    typedef struct packed {
        logic zoom_video_enable;
        logic port_sel;
        logic audio_to_mux_en;
        logic speaker_output_enable;
        logic card_function_irq_flag;
    } rtcc_sock_ctl_t;

endpackage

/* core/rtcc_reset_sync.sv */
// reset synchroniser: async assert, release through two flip-flops
module rtcc_reset_sync (
    // clock and raw reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // synchronised reset
    output logic      rst_sync_n
);

    logic meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q     <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            meta_q     <= 1'b1;
            rst_sync_n <= meta_q;
        end
    end

endmodule

/* core/rtcc_retry_timer.sv */
// one retry timeout counter: started by a retry, stopped by the master's return
module rtcc_retry_timer #(
    parameter int LIMIT = 32768
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // control
    input  wire logic enable,
    input  wire logic retry_issued,
    input  wire logic master_returned,
    // one-cycle pulse on timeout
    output logic      expired
);

    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

    logic [CW-1:0] cnt_q;
    logic          run_q;

    // a fresh retry restarts the count; return or disable stops it silently
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q   <= '0;
            run_q   <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (!enable) begin
                run_q <= 1'b0;
            end else if (retry_issued) begin
                run_q <= 1'b1;
                cnt_q <= '0;
            end else if (master_returned) begin
                run_q <= 1'b0;
            end else if (run_q) begin
                if (cnt_q == LAST) begin
                    run_q   <= 1'b0;
                    expired <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + CW'(1);
                end
            end
        end
    end

endmodule

/* core/rtcc_top.sv */
// retry timeout status and socket card control registers with their socket-side routing
//
// Overview of operation
// - a retried master not back within 2^15 clocks sets its expired flag
// - expired flags stay set until software writes one to them
// - bit 7 enables the host-side retry counter, resets to one
// - bit 6 enables the card-side retry counter, resets to one
// - bit 5 shows card target B retry expired, resets to zero
// - bit 3 shows card target A retry expired, resets to zero
// - bit 1 shows host target retry expired, resets to zero
// - retry status bits 4, 2 and 0 read as zero
// - retry status reached through function 0; global bits exist once, shared
// - ring output blocked unless enabled; then routed to terminals 2/4, and also to ring/pme while mux select is low
// - zoomed-video enable tri-states that socket's video terminals; resets zero
// - both sockets in video mode: port select picks socket 0 or 1
// - audio-to-mux routes card audio to mux output; socket 0 wins
// - speaker output is socket 0 speaker xor socket 1 speaker
// - speaker terminal driven only while some socket enables speaker output
// - per-socket interrupt flag set by card interrupt, cleared by writing one
// - card control bits 4 and 3 read as zero
module rtcc_top
    import rtcc_pkg::*;
#(
    parameter int RETRY_LIMIT = RTCC_RETRY_CYCLES
) (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    // configuration access
    input  wire rtcc_cfg_req_t cfg_req,
    output logic [7:0]         cfg_rdata,
    output logic               cfg_rvalid,
    // retry events: index 0 host target, 1 card target a, 2 card target b
    input  wire logic [2:0]    retry_issued,
    input  wire logic [2:0]    master_returned,
    // ring indicate
    input  wire logic          ring_event,
    input  wire logic          ring_mux_select,
    output logic               ring_indicate_output,
    output logic               ring_to_multi_terminal,
    // zoomed video, one bit per socket
    output logic [1:0]         zv_hiz,
    output logic               video_select_socket_a,
    output logic               video_select_socket_b,
    // card audio
    input  wire logic [1:0]    card_audio_in,
    output logic               card_audio_mux_output,
    // speaker
    input  wire logic [1:0]    card_speaker_signal,
    output logic               speaker_output_terminal,
    output logic               speaker_output_oe_n,
    // functional interrupts, one per socket
    input  wire logic [1:0]    card_irq,
    output logic [1:0]         card_function_irq_flag
);

    logic           rst_sync_n;
    logic           host_retry_timer_en_q;
    logic           card_retry_timer_en_q;
    logic           host_target_expired_q;
    logic           card_target_a_expired_q;
    logic           card_target_b_expired_q;
    logic           ring_output_enable_q;
    rtcc_sock_ctl_t sock_q [2];
    logic [2:0]     timer_expired;
    logic [2:0]     timer_enable;
    logic           wr_retry;
    logic           wr_card;
    logic           wr_global;
    logic [7:0]     retry_view;
    logic [7:0]     card_view;
    logic [7:0]     rdata_d;
    logic [1:0]     irq_clear;
    logic           both_zv;

    // reset release through two flops
    rtcc_reset_sync u_rst (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .rst_sync_n (rst_sync_n)
    );

    // host timer follows bit 7, both card timers follow the shared bit 6
    assign timer_enable[0] = host_retry_timer_en_q;
    assign timer_enable[1] = card_retry_timer_en_q;
    assign timer_enable[2] = card_retry_timer_en_q;

    // one counter per retried target
    for (genvar i = 0; i < 3; i++) begin : g_timer
        rtcc_retry_timer #(
            .LIMIT (RETRY_LIMIT)
        ) u_timer (
            .ref_clk         (ref_clk),
            .rst_n           (rst_sync_n),
            .enable          (timer_enable[i]),
            .retry_issued    (retry_issued[i]),
            .master_returned (master_returned[i]),
            .expired         (timer_expired[i])
        );
    end

    // write decode; retry status only answers function 0
    assign wr_retry  = cfg_req.wr && (cfg_req.addr == RTCC_OFS_RETRY) && (cfg_req.func == RTCC_FUNC_GLOBAL);
    assign wr_card   = cfg_req.wr && (cfg_req.addr == RTCC_OFS_CARD);
    assign wr_global = wr_card && (cfg_req.func == RTCC_FUNC_GLOBAL);

    // counter enables, plain read/write
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            host_retry_timer_en_q <= RTCC_RST_TIMER_EN;
            card_retry_timer_en_q <= RTCC_RST_TIMER_EN;
        end else if (wr_retry) begin
            host_retry_timer_en_q <= cfg_req.wdata[RTCC_RS_HOST_EN];
            card_retry_timer_en_q <= cfg_req.wdata[RTCC_RS_CARD_EN];
        end
    end

    // expired flags: a timeout in the same cycle as a clear keeps the flag set
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            host_target_expired_q   <= RTCC_RST_FLAG;
            card_target_a_expired_q <= RTCC_RST_FLAG;
            card_target_b_expired_q <= RTCC_RST_FLAG;
        end else begin
            if (timer_expired[0]) begin
                host_target_expired_q <= 1'b1;
            end else if (wr_retry && cfg_req.wdata[RTCC_RS_EXP_HOST]) begin
                host_target_expired_q <= 1'b0;
            end
            if (timer_expired[1]) begin
                card_target_a_expired_q <= 1'b1;
            end else if (wr_retry && cfg_req.wdata[RTCC_RS_EXP_A]) begin
                card_target_a_expired_q <= 1'b0;
            end
            if (timer_expired[2]) begin
                card_target_b_expired_q <= 1'b1;
            end else if (wr_retry && cfg_req.wdata[RTCC_RS_EXP_B]) begin
                card_target_b_expired_q <= 1'b0;
            end
        end
    end

    // ring enable exists once; function 1 writes cannot touch it
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ring_output_enable_q <= RTCC_RST_FLAG;
        end else if (wr_global) begin
            ring_output_enable_q <= cfg_req.wdata[RTCC_CC_RING_EN];
        end
    end

    // interrupt flag clear requests per socket
    assign irq_clear[0] = wr_card && (cfg_req.func == 1'h0) && cfg_req.wdata[RTCC_CC_IRQ_FLAG];
    assign irq_clear[1] = wr_card && (cfg_req.func == 1'h1) && cfg_req.wdata[RTCC_CC_IRQ_FLAG];

    // per-socket control bits, selected by the function number of the write
    for (genvar s = 0; s < 2; s++) begin : g_sock
        always_ff @(posedge ref_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                sock_q[s] <= '0;
            end else begin
                if (wr_card && (cfg_req.func == 1'(s))) begin
                    sock_q[s].zoom_video_enable     <= cfg_req.wdata[RTCC_CC_ZV_EN];
                    sock_q[s].port_sel              <= cfg_req.wdata[RTCC_CC_PORT_SEL];
                    sock_q[s].audio_to_mux_en       <= cfg_req.wdata[RTCC_CC_AUD_EN];
                    sock_q[s].speaker_output_enable <= cfg_req.wdata[RTCC_CC_SPK_EN];
                end
                // arrival beats a simultaneous clear so no interrupt is lost
                if (card_irq[s]) begin
                    sock_q[s].card_function_irq_flag <= 1'b1;
                end else if (irq_clear[s]) begin
                    sock_q[s].card_function_irq_flag <= 1'b0;
                end
            end
        end
    end

    // read views; reserved positions stay zero
    always_comb begin
        retry_view                   = 8'h00;
        retry_view[RTCC_RS_HOST_EN]  = host_retry_timer_en_q;
        retry_view[RTCC_RS_CARD_EN]  = card_retry_timer_en_q;
        retry_view[RTCC_RS_EXP_B]    = card_target_b_expired_q;
        retry_view[RTCC_RS_EXP_A]    = card_target_a_expired_q;
        retry_view[RTCC_RS_EXP_HOST] = host_target_expired_q;
    end

    always_comb begin
        card_view                   = 8'h00;
        card_view[RTCC_CC_RING_EN]  = ring_output_enable_q;
        card_view[RTCC_CC_ZV_EN]    = sock_q[cfg_req.func].zoom_video_enable;
        card_view[RTCC_CC_PORT_SEL] = sock_q[cfg_req.func].port_sel;
        card_view[RTCC_CC_AUD_EN]   = sock_q[cfg_req.func].audio_to_mux_en;
        card_view[RTCC_CC_SPK_EN]   = sock_q[cfg_req.func].speaker_output_enable;
        card_view[RTCC_CC_IRQ_FLAG] = sock_q[cfg_req.func].card_function_irq_flag;
    end

    // read mux; function 1 reads of the retry offset and unmapped offsets read zero
    always_comb begin
        rdata_d = RTCC_RST_RDATA;
        if (cfg_req.addr == RTCC_OFS_RETRY && cfg_req.func == RTCC_FUNC_GLOBAL) begin
            rdata_d = retry_view;
        end else if (cfg_req.addr == RTCC_OFS_CARD) begin
            rdata_d = card_view;
        end
    end

    // read answer one cycle after the request; data holds until the next read
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cfg_rdata  <= RTCC_RST_RDATA;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_req.rd;
            if (cfg_req.rd) begin
                cfg_rdata <= rdata_d;
            end
        end
    end

    // ring indicate: blocked entirely while the shared enable is clear
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ring_indicate_output   <= 1'b0;
            ring_to_multi_terminal <= 1'b0;
        end else begin
            ring_indicate_output   <= ring_output_enable_q && !ring_mux_select && ring_event;
            ring_to_multi_terminal <= ring_output_enable_q && ring_event;
        end
    end

    assign both_zv = sock_q[0].zoom_video_enable && sock_q[1].zoom_video_enable;

    // zoomed video: tri-state request and socket priority select
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            zv_hiz                <= 2'h0;
            video_select_socket_a <= 1'b0;
            video_select_socket_b <= 1'b0;
        end else begin
            zv_hiz <= {sock_q[1].zoom_video_enable, sock_q[0].zoom_video_enable};
            if (both_zv) begin
                // priority taken from the global function's port select
                video_select_socket_a <= !sock_q[0].port_sel;
                video_select_socket_b <= sock_q[0].port_sel;
            end else begin
                video_select_socket_a <= sock_q[0].zoom_video_enable;
                video_select_socket_b <= sock_q[1].zoom_video_enable;
            end
        end
    end

    // card audio to the mux output, socket 0 first
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            card_audio_mux_output <= 1'b0;
        end else if (sock_q[0].audio_to_mux_en) begin
            card_audio_mux_output <= card_audio_in[0];
        end else if (sock_q[1].audio_to_mux_en) begin
            card_audio_mux_output <= card_audio_in[1];
        end else begin
            card_audio_mux_output <= 1'b0;
        end
    end

    // speaker: xor of both sockets, driven only while any socket enables it
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            speaker_output_terminal <= 1'b0;
            speaker_output_oe_n     <= 1'b1;
        end else begin
            speaker_output_terminal <= card_speaker_signal[0] ^ card_speaker_signal[1];
            speaker_output_oe_n     <= !(sock_q[0].speaker_output_enable ||
                                         sock_q[1].speaker_output_enable);
        end
    end

    // interrupt flags to the pins through one more register, one cycle later
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            card_function_irq_flag <= 2'h0;
        end else begin
            card_function_irq_flag <= {sock_q[1].card_function_irq_flag, sock_q[0].card_function_irq_flag};
        end
    end

endmodule

/* sim/rtcc_top_props.sv */
// port-level assertions for the retry/card control block
module rtcc_top_props
    import rtcc_pkg::*;
(
    // clock and reset
    input wire logic          ref_clk,
    input wire logic          rst_n,
    // configuration access
    input wire rtcc_cfg_req_t cfg_req,
    input wire logic [7:0]    cfg_rdata,
    input wire logic          cfg_rvalid,
    // socket side
    input wire logic          ring_event,
    input wire logic          ring_mux_select,
    input wire logic          ring_indicate_output,
    input wire logic          ring_to_multi_terminal,
    input wire logic [1:0]    card_audio_in,
    input wire logic          card_audio_mux_output,
    input wire logic [1:0]    card_speaker_signal,
    input wire logic          speaker_output_terminal,
    input wire logic          speaker_output_oe_n,
    input wire logic [1:0]    card_irq,
    input wire logic [1:0]    card_function_irq_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // read requests of each register, the answer lands one cycle later
    sequence s_rd_retry;
        cfg_req.rd && cfg_req.addr == RTCC_OFS_RETRY;
    endsequence
    sequence s_rd_retry_f1;
        cfg_req.rd && cfg_req.func && cfg_req.addr == RTCC_OFS_RETRY;
    endsequence
    sequence s_rd_card;
        cfg_req.rd && cfg_req.addr == RTCC_OFS_CARD;
    endsequence

    a_read_answer: assert property (cfg_req.rd |=> cfg_rvalid) else $error("read not answered");
    a_retry_reserved: assert property (s_rd_retry |=> (cfg_rdata & 8'h15) == 8'h00)
        else $error("retry reserved bits set");
    a_card_reserved: assert property (s_rd_card |=> cfg_rdata[4:3] == 2'h0)
        else $error("card reserved bits set");
    a_retry_func_one: assert property (s_rd_retry_f1 |=> cfg_rdata == 8'h00)
        else $error("retry register seen from function one");
    a_speaker_xor: assert property (!speaker_output_oe_n |-> speaker_output_terminal == ^$past(card_speaker_signal))
        else $error("speaker not xor of sockets");
    a_ring_route: assert property (ring_indicate_output |-> ring_to_multi_terminal && $past(ring_event) && !$past(ring_mux_select))
        else $error("ring output without cause");
    a_audio_cause: assert property (card_audio_mux_output |-> |$past(card_audio_in))
        else $error("audio output without card audio");
    a_irq_zero_cause: assert property ($rose(card_function_irq_flag[0]) |-> $past(card_irq[0], 2))
        else $error("socket 0 flag without interrupt");
    a_irq_one_cause: assert property ($rose(card_function_irq_flag[1]) |-> $past(card_irq[1], 2))
        else $error("socket 1 flag without interrupt");
endmodule

/* sim/rtcc_master_model.sv */
// retried bus masters: take a retry, come back after a set delay or never
module rtcc_master_model (
    // clock
    input  wire logic       ref_clk,
    // command: retry master idx, return after dly cycles, 0 means never
    input  wire logic       go,
    input  wire logic [1:0] idx,
    input  wire logic [7:0] dly,
    // retry events toward the bridge
    output logic      [2:0] retry_issued,
    output logic      [2:0] master_returned
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wait_q [3] = '{default: 8'h00};
    logic [2:0] iss_q = 3'h0;
    logic [2:0] ret_q = 3'h0;

    assign retry_issued    = iss_q;
    assign master_returned = ret_q;

    // each master keeps its own wait, so retrying one never cancels another's return
    always @(posedge ref_clk) begin
        for (int m = 0; m < 3; m++) begin
            iss_q[m] <= go && (idx == 2'(m));
            ret_q[m] <= !(go && (idx == 2'(m))) && (wait_q[m] == 8'h01);
            if (go && (idx == 2'(m))) begin
                wait_q[m] <= dly;
            end else if (wait_q[m] != 8'h00) begin
                wait_q[m] <= wait_q[m] - 8'h01;
            end
        end
    end
endmodule

/* sim/rtcc_top_tb.sv */
// self-checking bench for the retry/card control block
module rtcc_top_tb
    import rtcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 16;  // short timeout keeps the run brief
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    rtcc_cfg_req_t cfg_req = '0;
    logic [7:0] cfg_rdata, m_dly = 8'h00;
    logic cfg_rvalid, m_go = 1'b0;
    logic [1:0] m_idx = 2'h0, card_irq = 2'h0, card_audio_in = 2'h0, card_speaker_signal = 2'h0;
    logic ring_event = 1'b0, ring_mux_select = 1'b0;
    logic [2:0] retry_issued, master_returned;
    logic ring_indicate_output, ring_to_multi_terminal, video_select_socket_a, video_select_socket_b;
    logic card_audio_mux_output, speaker_output_terminal, speaker_output_oe_n;
    logic [1:0] zv_hiz, card_function_irq_flag;
    logic [7:0] exp_q[$];
    int n_mismatch = 0, checked = 0, seed = 7485;

    rtcc_top #(.RETRY_LIMIT(LIMIT)) i_rtcc_top (.ref_clk(ref_clk), .rst_n(rst_n), .cfg_req(cfg_req),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .retry_issued(retry_issued),
        .master_returned(master_returned), .ring_event(ring_event), .ring_mux_select(ring_mux_select),
        .ring_indicate_output(ring_indicate_output), .ring_to_multi_terminal(ring_to_multi_terminal),
        .zv_hiz(zv_hiz), .video_select_socket_a(video_select_socket_a),
        .video_select_socket_b(video_select_socket_b), .card_audio_in(card_audio_in),
        .card_audio_mux_output(card_audio_mux_output), .card_speaker_signal(card_speaker_signal),
        .speaker_output_terminal(speaker_output_terminal), .speaker_output_oe_n(speaker_output_oe_n),
        .card_irq(card_irq), .card_function_irq_flag(card_function_irq_flag));
    rtcc_master_model i_rtcc_master_model (.ref_clk(ref_clk), .go(m_go), .idx(m_idx), .dly(m_dly),
        .retry_issued(retry_issued), .master_returned(master_returned));

    always #5 ref_clk = ~ref_clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // one config cycle; a read leaves its expected byte for the monitor
    task automatic cfg(input logic wr, input logic func, input logic [7:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        cfg_req <= '{wr: wr, rd: !wr, func: func, addr: addr, wdata: data};
        if (!wr) exp_q.push_back(data);
        @(posedge ref_clk);
        cfg_req <= '0;
    endtask

    task automatic issue(input logic [1:0] idx, input logic [7:0] dly);
        @(posedge ref_clk);
        m_go <= 1'b1;
        m_idx <= idx;
        m_dly <= dly;
        @(posedge ref_clk);
        m_go <= 1'b0;
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // read answers are matched against the oldest note
    always @(posedge ref_clk) begin
        if (cfg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) check(16'hffff, 16'h0000);
            else check({8'h00, cfg_rdata}, {8'h00, exp_q.pop_front()});
        end
    end

    initial begin
        repeat (6000) @(posedge ref_clk);
        n_mismatch++;
        results();
    end

    initial begin
        logic [7:0] bm, d0, d1;
        logic [5:0] p;
        logic both;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check({15'h0, speaker_output_oe_n}, 16'h0001);
        cfg(0, 0, RTCC_OFS_RETRY, 8'hc0);
        cfg(0, 0, RTCC_OFS_CARD, 8'h00);
        cfg(0, 1, RTCC_OFS_CARD, 8'h00);
        $display("reset values done");
        for (int i = 0; i < 3; i++) begin
            bm = 8'h02 << (2 * i);
            issue(i[1:0], 8'h00);
            repeat (LIMIT + 6) @(posedge ref_clk);
            cfg(0, 0, RTCC_OFS_RETRY, 8'hc0 | bm);
            cfg(1, 0, RTCC_OFS_RETRY, 8'hc0);
            cfg(0, 0, RTCC_OFS_RETRY, 8'hc0 | bm);
            cfg(1, 0, RTCC_OFS_RETRY, 8'hc0 | bm);
            cfg(0, 0, RTCC_OFS_RETRY, 8'hc0);
        end
        $display("expiry flags done");
        issue(2'h0, 8'd8);
        issue(2'h1, 8'h00);
        repeat (LIMIT - 4) @(posedge ref_clk);
        issue(2'h1, 8'd6);
        repeat (LIMIT + 6) @(posedge ref_clk);
        cfg(0, 0, RTCC_OFS_RETRY, 8'hc0);
        cfg(1, 0, RTCC_OFS_RETRY, 8'h00);
        for (int i = 0; i < 3; i++) issue(i[1:0], 8'h00);
        repeat (LIMIT + 6) @(posedge ref_clk);
        cfg(0, 0, RTCC_OFS_RETRY, 8'h00);
        cfg(1, 0, RTCC_OFS_RETRY, 8'hc0);
        cfg(1, 1, RTCC_OFS_RETRY, 8'h00);
        cfg(0, 1, RTCC_OFS_RETRY, 8'h00);
        cfg(0, 0, RTCC_OFS_RETRY, 8'hc0);
        $display("retry counters done");
        for (int i = 0; i < 12; i++) begin
            d0 = 8'($random(seed));
            d1 = 8'($random(seed));
            p = 6'($random(seed));
            cfg(1, 0, RTCC_OFS_CARD, d0);
            cfg(1, 1, RTCC_OFS_CARD, d1);
            cfg(0, 0, RTCC_OFS_CARD, d0 & 8'he6);
            cfg(0, 1, RTCC_OFS_CARD, (d0 & 8'h80) | (d1 & 8'h66));
            @(posedge ref_clk);
            {ring_event, ring_mux_select, card_audio_in, card_speaker_signal} <= p;
            repeat (3) @(posedge ref_clk);
            both = d0[6] & d1[6];
            check({zv_hiz, video_select_socket_a, video_select_socket_b, ring_indicate_output,
                   ring_to_multi_terminal, card_audio_mux_output, speaker_output_terminal & !speaker_output_oe_n,
                   speaker_output_oe_n},
                  {d1[6], d0[6], both ? !d0[5] : d0[6], both ? d0[5] : d1[6], d0[7] & p[5] & !p[4], d0[7] & p[5],
                   d0[2] ? p[2] : d1[2] & p[3], ^p[1:0] & (d0[1] | d1[1]), !(d0[1] | d1[1])});
        end
        cfg(1, 0, RTCC_OFS_CARD, 8'h00);
        cfg(1, 1, RTCC_OFS_CARD, 8'h00);
        $display("card control done");
        for (int s = 0; s < 2; s++) begin
            @(posedge ref_clk);
            card_irq <= 2'b01 << s;
            @(posedge ref_clk);
            card_irq <= 2'b00;
            repeat (2) @(posedge ref_clk);
            check({14'h0, card_function_irq_flag}, 16'h0001 << s);
            cfg(0, !s[0], RTCC_OFS_CARD, 8'h00);
            cfg(1, s[0], RTCC_OFS_CARD, 8'h00);
            cfg(0, s[0], RTCC_OFS_CARD, 8'h01);
            cfg(1, s[0], RTCC_OFS_CARD, 8'h01);
            cfg(0, s[0], RTCC_OFS_CARD, 8'h00);
        end
        repeat (4) @(posedge ref_clk);
        $display("interrupt flags done");
        results();
    end
endmodule

bind rtcc_top rtcc_top_props i_rtcc_top_props (.ref_clk(ref_clk), .rst_n(rst_n), .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .ring_event(ring_event), .ring_mux_select(ring_mux_select),
    .ring_indicate_output(ring_indicate_output), .ring_to_multi_terminal(ring_to_multi_terminal),
    .card_audio_in(card_audio_in), .card_audio_mux_output(card_audio_mux_output),
    .card_speaker_signal(card_speaker_signal), .speaker_output_terminal(speaker_output_terminal),
    .speaker_output_oe_n(speaker_output_oe_n), .card_irq(card_irq),
    .card_function_irq_flag(card_function_irq_flag));
